// file: rtl/dacr_router.sv
// Top: dual address bus front end with command parsing and serial routing
`timescale 1ns/10ps

module dacr_router
  import dacr_pkg::*;
(
  input  wire logic       CLK_I,
  input  wire logic       RESETN_I,
  input  wire logic [4:0] SW_ADDR_I,       // Configuration switch, asynchronous
  input  wire logic       ADDR_VALID_I,    // Address byte strobe from bus interface
  input  wire logic [4:0] ADDR_I,          // Primary address carried
  input  wire logic       ADDR_TALK_I,     // 1 talk address, 0 listen address
  input  wire logic       UNADDR_I,        // Untalk/unlisten or clear
  input  wire logic       LDATA_VALID_I,   // Listener byte from bus
  input  wire dacr_byte_s LDATA_I,
  output logic            LDATA_READY_O,
  output logic            TDATA_VALID_O,   // Talker byte to bus
  output dacr_byte_s      TDATA_O,
  input  wire logic       TDATA_READY_I,
  input  wire logic       SER_RX_VALID_I,  // Received serial byte
  input  wire dacr_ser_s  SER_RX_I,
  output logic            SER_TX_VALID_O,  // Byte to serial transmitter
  output logic [7:0]      SER_TX_DATA_O,
  input  wire logic       SER_TX_READY_I,
  output logic            SER_ERR_O,       // Recorded serial error
  output logic            EOS_ENABLE_O,    // End-of-string matching allowed
  output logic            LISTEN_LED_O,
  output logic            TALK_LED_O
);

  // ----------------------------------------------------------------------
  // Switch synchroniser and addresses
  // ----------------------------------------------------------------------
  logic [4:0] sw_meta_q;
  logic [4:0] sw_q;
  logic [4:0] own_addr;
  logic [4:0] comp_addr;

  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      sw_meta_q <= 5'h00;
      sw_q      <= 5'h00;
    end else begin
      sw_meta_q <= SW_ADDR_I;
      sw_q      <= sw_meta_q;
    end
  end

  assign own_addr  = sw_q;
  assign comp_addr = (sw_q == DACR_ADDR_WRAP) ? DACR_ADDR_WRAP_COMP
                                              : sw_q + DACR_ADDR_STEP;

  // ----------------------------------------------------------------------
  // Address state: talk holds one of own or companion; listen can hold both
  // ----------------------------------------------------------------------
  logic own_lsn_q;
  logic comp_lsn_q;
  logic own_tlk_q;
  logic comp_tlk_q;

  // A talk address drops the other talker; listen addresses stack
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I || UNADDR_I) begin
      own_lsn_q  <= 1'b0;
      comp_lsn_q <= 1'b0;
      own_tlk_q  <= 1'b0;
      comp_tlk_q <= 1'b0;
    end else if (ADDR_VALID_I) begin
      if (ADDR_TALK_I) begin
        own_tlk_q  <= (ADDR_I == own_addr);
        comp_tlk_q <= (ADDR_I == comp_addr);
      end else begin
        if (ADDR_I == own_addr) own_lsn_q <= 1'b1;
        if (ADDR_I == comp_addr) comp_lsn_q <= 1'b1;
      end
    end
  end

  assign LISTEN_LED_O = own_lsn_q || comp_lsn_q;
  assign TALK_LED_O   = own_tlk_q || comp_tlk_q;
  assign EOS_ENABLE_O = comp_tlk_q;

  // ----------------------------------------------------------------------
  // Line buffer and command flow
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    DACR_L_FILL = 2'b00,
    DACR_L_DEC  = 2'b01,
    DACR_L_EXEC = 2'b10
  } dacr_lst_e;

  logic [7:0] line_q [DACR_LINE_DEPTH];
  dacr_lst_e  lst_q;
  logic [5:0] llen_q;
  logic       cr_seen_q;
  logic       is_term;
  logic       own_take;
  logic       comp_take;
  logic [5:0] p_idx;
  logic       p_done;
  dacr_cmd_e  p_cmd;
  logic       p_arg;
  logic [7:0] p_ch;
  // Line close and executed-command strobes
  logic       line_end;
  logic       exec_stat;
  logic       exec_spign;

  assign is_term   = (LDATA_I.data == DACR_CH_CR) || (LDATA_I.data == DACR_CH_LF);
  // Own listener bytes wait while a line decodes; this back-pressures the bus
  assign own_take  = LDATA_VALID_I && own_lsn_q && (lst_q == DACR_L_FILL);
  assign comp_take = LDATA_VALID_I && comp_lsn_q && !own_lsn_q && SER_TX_READY_I;
  assign LDATA_READY_O = own_lsn_q ? (lst_q == DACR_L_FILL)
                       : comp_lsn_q ? SER_TX_READY_I : 1'b1;
  assign p_ch = line_q[p_idx[4:0]];
  // A LF straight after CR closes nothing; it must not start the parser either
  assign line_end   = own_take && is_term
                      && (!(cr_seen_q && LDATA_I.data == DACR_CH_LF) || llen_q != DACR_PTR_RST);
  // Executed command, decoded once for the error flag and the talker
  assign exec_stat  = (lst_q == DACR_L_EXEC) && (p_cmd == DACR_CMD_STAT);
  assign exec_spign = (lst_q == DACR_L_EXEC) && (p_cmd == DACR_CMD_SPIGN);

  // Bytes of the line, stored until a terminator closes it
  always_ff @(posedge CLK_I) begin
    if (own_take && !is_term && (llen_q != 6'(DACR_LINE_DEPTH))) begin
      line_q[llen_q[4:0]] <= LDATA_I.data;
    end
  end

  // Fill, decode and execute one line at a time
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      lst_q     <= DACR_L_FILL;
      llen_q    <= DACR_PTR_RST;
      cr_seen_q <= 1'b0;
    end else begin
      case (lst_q)
        DACR_L_FILL: begin
          if (own_take) begin
            cr_seen_q <= (LDATA_I.data == DACR_CH_CR);
            if (line_end) begin
              lst_q <= DACR_L_DEC;
            end else if (!is_term && (llen_q != 6'(DACR_LINE_DEPTH))) begin
              llen_q <= llen_q + 6'h01;
            end
          end
        end
        DACR_L_DEC: begin
          if (p_done) lst_q <= DACR_L_EXEC;
        end
        DACR_L_EXEC: begin
          lst_q  <= DACR_L_FILL;
          llen_q <= DACR_PTR_RST;
        end
        default: lst_q <= DACR_L_FILL;
      endcase
    end
  end

  dacr_line_parser u_parser (
    .CLK_I    (CLK_I),
    .RESETN_I (RESETN_I),
    .start_i  (line_end),
    .ch_i     (p_ch),
    .len_i    (llen_q),
    .idx_o    (p_idx),
    .done_o   (p_done),
    .cmd_o    (p_cmd),
    .arg_o    (p_arg)
  );

  // ----------------------------------------------------------------------
  // Serial side: forward companion bytes, buffer received bytes
  // ----------------------------------------------------------------------
  // Raw pass-through; own-address bytes never reach this path
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      SER_TX_VALID_O <= 1'b0;
      SER_TX_DATA_O  <= 8'h00;
    end else begin
      SER_TX_VALID_O <= comp_take;
      if (comp_take) SER_TX_DATA_O <= LDATA_I.data;
    end
  end

  logic       rx_empty;
  logic [4:0] rx_cnt;
  logic [7:0] rx_data;
  logic       rx_pop;
  logic       spign_q;

  dacr_rx_buffer u_rxbuf (
    .CLK_I     (CLK_I),
    .RESETN_I  (RESETN_I),
    .wr_i      (SER_RX_VALID_I),
    .wr_data_i (SER_RX_I.data),
    .rd_i      (rx_pop),
    .rd_data_o (rx_data),
    .empty_o   (rx_empty),
    .full_o    (),
    .count_o   (rx_cnt)
  );

  // Error flag: a new error wins over the clear done by reporting status
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      SER_ERR_O <= 1'b0;
      spign_q   <= 1'b0;
    end else begin
      if (exec_spign) spign_q <= p_arg;
      if (SER_RX_VALID_I && SER_RX_I.err && !spign_q) begin
        SER_ERR_O <= 1'b1;
      end else if (exec_stat) begin
        SER_ERR_O <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Talker output
  // ----------------------------------------------------------------------
  function automatic logic [7:0] hex_digit(input logic [3:0] v);
    hex_digit = (v < 4'hA) ? (8'h30 + {4'h0, v}) : (8'h37 + {4'h0, v});
  endfunction

  logic [7:0] stat_q [DACR_STAT_LEN];
  logic       stat_pend_q;
  logic [1:0] stat_idx_q;
  logic       idle_lf_q;
  logic       tx_fire;

  // A byte leaves on valid and ready; companion bytes pop the buffer
  assign tx_fire = TDATA_VALID_O && TDATA_READY_I;
  assign rx_pop  = tx_fire && comp_tlk_q;

  // Status text snapshots the buffer count when the stat line executes
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      stat_pend_q <= 1'b0;
      stat_idx_q  <= 2'h0;
      idle_lf_q   <= 1'b0;
      for (int i = 0; i < DACR_STAT_LEN; i++) stat_q[i] <= 8'h00;
    end else if (exec_stat) begin
      stat_pend_q <= 1'b1;
      stat_idx_q  <= 2'h0;
      stat_q[0]   <= hex_digit({3'h0, rx_cnt[4]});
      stat_q[1]   <= hex_digit(rx_cnt[3:0]);
      stat_q[2]   <= DACR_CH_CR;
      stat_q[3]   <= DACR_CH_LF;
    end else if (tx_fire && own_tlk_q) begin
      if (stat_pend_q) begin
        stat_idx_q <= stat_idx_q + 2'h1;
        if (stat_idx_q == 2'(DACR_STAT_LEN - 1)) stat_pend_q <= 1'b0;
      end else begin
        idle_lf_q <= !idle_lf_q;
      end
    end
  end

  // Byte presented to the bus; companion talk stalls on an empty buffer
  always_comb begin
    TDATA_VALID_O = 1'b0;
    TDATA_O       = '0;
    if (own_tlk_q) begin
      TDATA_VALID_O = 1'b1;
      if (stat_pend_q) begin
        TDATA_O.data = stat_q[stat_idx_q];
        TDATA_O.last = (stat_idx_q == 2'(DACR_STAT_LEN - 1));
      end else begin
        TDATA_O.data = idle_lf_q ? DACR_CH_LF : DACR_CH_CR;
        TDATA_O.last = idle_lf_q;
      end
    end else if (comp_tlk_q) begin
      TDATA_VALID_O = !rx_empty;
      TDATA_O.data  = rx_data;
    end
  end

endmodule // dacr_router

// file: rtl/dacr_pkg.sv
// Package: shared constants and types for the dual address command router
package dacr_pkg;

  // ----------------------------------------------------------------------
  // Bus addressing
  // ----------------------------------------------------------------------
  localparam logic [4:0] DACR_ADDR_WRAP      = 5'h1E;  // Primary address whose companion wraps
  localparam logic [4:0] DACR_ADDR_WRAP_COMP = 5'h00;  // Companion address after wrap
  localparam logic [4:0] DACR_ADDR_STEP      = 5'h01;  // Companion offset from own address

  // ----------------------------------------------------------------------
  // Characters
  // ----------------------------------------------------------------------
  localparam logic [7:0] DACR_CH_CR    = 8'h0D;
  localparam logic [7:0] DACR_CH_LF    = 8'h0A;
  localparam logic [7:0] DACR_CH_SP    = 8'h20;
  localparam logic [7:0] DACR_CH_COMMA = 8'h2C;
  localparam logic [7:0] DACR_CH_ZERO  = 8'h30;
  localparam logic [7:0] DACR_CH_ONE   = 8'h31;
  localparam logic [7:0] DACR_CH_S_UC  = 8'h53;
  localparam logic [7:0] DACR_CH_T_UC  = 8'h54;
  localparam logic [7:0] DACR_CH_P_UC  = 8'h50;
  localparam logic [7:0] DACR_CH_I_UC  = 8'h49;

  // ----------------------------------------------------------------------
  // Sizes and reset values
  // ----------------------------------------------------------------------
  localparam int         DACR_LINE_DEPTH = 32;     // Message line buffer bytes
  localparam int         DACR_RX_DEPTH   = 16;     // Serial receive buffer bytes
  localparam int         DACR_STAT_LEN   = 4;      // Status text: 2 hex digits, CR, LF
  localparam logic [4:0] DACR_CNT_RST    = 5'h00;
  localparam logic [5:0] DACR_PTR_RST    = 6'h00;

  // ----------------------------------------------------------------------
  // Decoded command codes
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    DACR_CMD_NONE  = 2'b00,
    DACR_CMD_STAT  = 2'b01,  // Queue status text
    DACR_CMD_SPIGN = 2'b10   // Set serial error ignore
  } dacr_cmd_e;

  // Bus byte with its end indication
  typedef struct packed {
    logic [7:0] data;
    logic       last;
  } dacr_byte_s;

  // Serial receive byte with its error flag
  typedef struct packed {
    logic [7:0] data;
    logic       err;
  } dacr_ser_s;

endpackage

// file: rtl/dacr_rx_buffer.sv
// Serial receive buffer for the dual address command router
`timescale 1ns/10ps
module dacr_rx_buffer
  import dacr_pkg::*;
(
  input  wire logic       CLK_I,
  input  wire logic       RESETN_I,
  input  wire logic       wr_i,
  input  wire logic [7:0] wr_data_i,
  input  wire logic       rd_i,
  output logic [7:0]      rd_data_o,
  output logic            empty_o,
  output logic            full_o,
  output logic [4:0]      count_o
);

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  logic [7:0] mem_q [DACR_RX_DEPTH];
  logic [3:0] wp_q;
  logic [3:0] rp_q;
  logic [4:0] cnt_q;
  logic       do_wr;
  logic       do_rd;

  // Writes into a full buffer are dropped; the sender loses the byte
  assign do_wr     = wr_i && (cnt_q != 5'(DACR_RX_DEPTH));
  assign do_rd     = rd_i && (cnt_q != DACR_CNT_RST);
  assign empty_o   = (cnt_q == DACR_CNT_RST);
  assign full_o    = (cnt_q == 5'(DACR_RX_DEPTH));
  assign count_o   = cnt_q;
  assign rd_data_o = mem_q[rp_q];

  // Data array
  always_ff @(posedge CLK_I) begin
    if (do_wr) begin
      mem_q[wp_q] <= wr_data_i;
    end
  end

  // Pointers and fill count
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      wp_q  <= 4'h0;
      rp_q  <= 4'h0;
      cnt_q <= DACR_CNT_RST;
    end else begin
      if (do_wr) begin
        wp_q <= wp_q + 4'h1;
      end
      if (do_rd) begin
        rp_q <= rp_q + 4'h1;
      end
      cnt_q <= cnt_q + 5'(do_wr) - 5'(do_rd);
    end
  end

endmodule // dacr_rx_buffer

// file: rtl/dacr_line_parser.sv
// Line decoder: splits a buffered message into name and boolean argument
`timescale 1ns/10ps
module dacr_line_parser
  import dacr_pkg::*;
(
  input  wire logic       CLK_I,
  input  wire logic       RESETN_I,
  input  wire logic       start_i,
  input  wire logic [7:0] ch_i,
  input  wire logic [5:0] len_i,
  output logic [5:0]      idx_o,
  output logic            done_o,
  output dacr_cmd_e       cmd_o,
  output logic            arg_o
);

  // Upper-case a letter so names match in any case
  function automatic logic [7:0] to_upper(input logic [7:0] c);
    to_upper = ((c >= 8'h61) && (c <= 8'h7A)) ? (c - 8'h20) : c;
  endfunction

  // ----------------------------------------------------------------------
  // Scan state
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    DACR_P_IDLE = 2'b00,
    DACR_P_NAME = 2'b01,
    DACR_P_ARG  = 2'b10
  } dacr_pst_e;

  dacr_pst_e  st_q;
  logic [5:0] idx_q;
  logic [2:0] nlen_q;
  logic [7:0] c0_q;
  logic [7:0] c2_q;
  logic       arg_q;
  logic       sep_q;
  logic [7:0] uc;
  logic       is_sep;

  assign uc     = to_upper(ch_i);
  assign is_sep = (ch_i == DACR_CH_SP) || (ch_i == DACR_CH_COMMA);
  assign idx_o  = idx_q;

  // Walk the line one byte a cycle, then report the decoded command
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      st_q   <= DACR_P_IDLE;
      idx_q  <= DACR_PTR_RST;
      nlen_q <= 3'h0;
      c0_q   <= 8'h00;
      c2_q   <= 8'h00;
      arg_q  <= 1'b0;
      sep_q  <= 1'b0;
      done_o <= 1'b0;
      cmd_o  <= DACR_CMD_NONE;
      arg_o  <= 1'b0;
    end else begin
      done_o <= 1'b0;
      case (st_q)
        DACR_P_IDLE: begin
          if (start_i) begin
            st_q   <= DACR_P_NAME;
            idx_q  <= DACR_PTR_RST;
            nlen_q <= 3'h0;
            c0_q   <= 8'h00;
            c2_q   <= 8'h00;
            arg_q  <= 1'b0;
            sep_q  <= 1'b0;
          end
        end
        DACR_P_NAME: begin
          if (idx_q == len_i) begin
            st_q <= DACR_P_ARG;
          end else if (ch_i == DACR_CH_SP) begin
            st_q <= DACR_P_ARG;
            idx_q <= idx_q + 6'h01;
          end else begin
            if (nlen_q == 3'h0) c0_q <= uc;
            if (nlen_q == 3'h2) c2_q <= uc;
            if (nlen_q != 3'h7) nlen_q <= nlen_q + 3'h1;
            idx_q <= idx_q + 6'h01;
          end
        end
        DACR_P_ARG: begin
          if (idx_q == len_i) begin
            // Prefix checks: "s" and a second letter for stat, "s" with "i" third for the ignore flag
            st_q   <= DACR_P_IDLE;
            done_o <= 1'b1;
            arg_o  <= arg_q;
            if (c0_q == DACR_CH_S_UC && nlen_q >= 3'h3 && c2_q == DACR_CH_I_UC) begin
              cmd_o <= DACR_CMD_SPIGN;
            end else if (c0_q == DACR_CH_S_UC && nlen_q >= 3'h2 && c2_q != DACR_CH_I_UC) begin
              cmd_o <= DACR_CMD_STAT;
            end else begin
              cmd_o <= DACR_CMD_NONE;
            end
          end else begin
            idx_q <= idx_q + 6'h01;
            // Separators are skipped; only the first argument is decoded
            if (!is_sep && !sep_q) begin
              sep_q <= 1'b1;
              // First argument digit: 1 is on, 0 is off
              if (ch_i == DACR_CH_ONE) arg_q <= 1'b1;
              if (ch_i == DACR_CH_ZERO) arg_q <= 1'b0;
            end
          end
        end
        default: st_q <= DACR_P_IDLE;
      endcase
    end
  end

endmodule // dacr_line_parser

// file: dv/dacr_router_props.sv
// Port assertions for the dual address command router
`timescale 1ns/10ps
module dacr_router_props
  import dacr_pkg::*;
(
  input  wire logic       CLK_I,
  input  wire logic       RESETN_I,
  input  wire logic [4:0] SW_ADDR_I,
  input  wire logic       ADDR_VALID_I,
  input  wire logic [4:0] ADDR_I,
  input  wire logic       ADDR_TALK_I,
  input  wire logic       UNADDR_I,
  input  wire logic       LDATA_VALID_I,
  input  wire dacr_byte_s LDATA_I,
  input  wire logic       LDATA_READY_O,
  input  wire logic       TDATA_VALID_O,
  input  wire dacr_byte_s TDATA_O,
  input  wire logic       TDATA_READY_I,
  input  wire logic       SER_RX_VALID_I,
  input  wire dacr_ser_s  SER_RX_I,
  input  wire logic       SER_TX_VALID_O,
  input  wire logic [7:0] SER_TX_DATA_O,
  input  wire logic       SER_ERR_O,
  input  wire logic       EOS_ENABLE_O,
  input  wire logic       LISTEN_LED_O,
  input  wire logic       TALK_LED_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RESETN_I);
  logic [4:0] comp;
  logic       hit;
  logic       acc;
  // Companion of the top primary address wraps to zero
  assign comp = (SW_ADDR_I == 5'h1E) ? 5'h00 : SW_ADDR_I + 5'h01;
  assign hit  = ADDR_VALID_I && !UNADDR_I && (ADDR_I == SW_ADDR_I || ADDR_I == comp);
  assign acc  = LDATA_VALID_I && LDATA_READY_O;

  chk_tx_source: assert property (
    SER_TX_VALID_O |-> $past(acc) && SER_TX_DATA_O == $past(LDATA_I.data))
    else $error("serial byte without matching bus byte");
  chk_listen_led: assert property (
    hit && !ADDR_TALK_I |=> LISTEN_LED_O) else $error("listen lamp off after address");
  chk_talk_led: assert property (
    hit && ADDR_TALK_I |=> TALK_LED_O && EOS_ENABLE_O == ($past(ADDR_I) == comp))
    else $error("talk lamp or string matching wrong");
  chk_unaddr_clear: assert property (
    UNADDR_I && !ADDR_VALID_I |=> !LISTEN_LED_O && !TALK_LED_O) else $error("lamps stay on");
  chk_eos_talk: assert property (
    EOS_ENABLE_O |-> TALK_LED_O) else $error("string matching while not talking");
  chk_err_cause: assert property (
    $rose(SER_ERR_O) |-> $past(SER_RX_VALID_I) && $past(SER_RX_I.err))
    else $error("serial error without bad byte");
  chk_stray_bytes: assert property (
    LDATA_VALID_I && !LISTEN_LED_O |-> LDATA_READY_O ##1 !SER_TX_VALID_O)
    else $error("unaddressed byte not dropped");
  chk_cr_then_lf: assert property (
    TDATA_VALID_O && TDATA_READY_I && TALK_LED_O && !EOS_ENABLE_O && TDATA_O.data == 8'h0D
    |=> TDATA_VALID_O && TDATA_O.data == 8'h0A && TDATA_O.last) else $error("bad status end");
  chk_data_talk: assert property (
    TDATA_VALID_O |-> TALK_LED_O) else $error("talker data while not talking");

  cov_tx: cover property (SER_TX_VALID_O);
  cov_end: cover property (TDATA_VALID_O && TDATA_READY_I && TDATA_O.last);
  cov_err: cover property ($rose(SER_ERR_O));
endmodule // dacr_router_props

bind dacr_router dacr_router_props dacr_router_props_inst (.CLK_I, .RESETN_I, .SW_ADDR_I,
  .ADDR_VALID_I, .ADDR_I, .ADDR_TALK_I, .UNADDR_I, .LDATA_VALID_I, .LDATA_I, .LDATA_READY_O,
  .TDATA_VALID_O, .TDATA_O, .TDATA_READY_I, .SER_RX_VALID_I, .SER_RX_I, .SER_TX_VALID_O,
  .SER_TX_DATA_O, .SER_ERR_O, .EOS_ENABLE_O, .LISTEN_LED_O, .TALK_LED_O);

// file: dv/dacr_bus_ctl.sv
// Bus controller model: addresses, writes listener bytes, reads talker bytes
`timescale 1ns/10ps
module dacr_bus_ctl
  import dacr_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       ldata_ready_i,
  input  wire logic       tdata_valid_i,
  input  wire dacr_byte_s tdata_i,
  output logic            addr_valid_o,
  output logic [4:0]      addr_o,
  output logic            addr_talk_o,
  output logic            unaddr_o,
  output logic            ldata_valid_o,
  output dacr_byte_s      ldata_o,
  output logic            tdata_ready_o
);
  // Handshakes that ran out of time; the bench counts them as mismatches
  int n_stall = 0;
  initial begin
    addr_valid_o = 1'b0;
    addr_o = 5'h00;
    addr_talk_o = 1'b0;
    unaddr_o = 1'b0;
    ldata_valid_o = 1'b0;
    ldata_o = '0;
    tdata_ready_o = 1'b0;
  end
  // Transfers follow an address byte, except one sent with nothing addressed to check it is dropped
  task automatic addr(input logic [4:0] a, input logic t);
    @(posedge clk_i) #1;
    addr_valid_o = 1'b1;
    addr_o = a;
    addr_talk_o = t;
    @(posedge clk_i) #1;
    addr_valid_o = 1'b0;
    addr_o = ~a; // Released field must not look like a held address
  endtask
  task automatic unaddr();
    @(posedge clk_i) #1;
    unaddr_o = 1'b1;
    @(posedge clk_i) #1;
    unaddr_o = 1'b0;
  endtask
  // Each byte held until ready is seen at an edge; end marks the final byte
  task automatic wr(input string s);
    int w;
    logic ok;
    @(posedge clk_i) #1;
    for (int i = 0; i < s.len(); i++) begin
      ldata_valid_o = 1'b1;
      ldata_o = '{s[i], i == s.len() - 1};
      w = 0;
      // Ready read mid-cycle, as the next edge will see it
      do begin
        @(negedge clk_i);
        ok = (ldata_ready_i === 1'b1);
        @(posedge clk_i);
        w++;
      end while (!ok && w < 200);
      if (!ok) n_stall++;
      #1;
    end
    ldata_valid_o = 1'b0;
    ldata_o = ~ldata_o;
  endtask
  task automatic rd(output dacr_byte_s b);
    int w;
    logic ok;
    @(posedge clk_i) #1;
    tdata_ready_o = 1'b1;
    w = 0;
    do begin
      @(negedge clk_i);
      ok = (tdata_valid_i === 1'b1);
      b = tdata_i;
      @(posedge clk_i);
      w++;
    end while (!ok && w < 200);
    if (!ok) n_stall++;
    #1;
    tdata_ready_o = 1'b0;
  endtask
endmodule // dacr_bus_ctl

// file: dv/dacr_router_tb.sv
// Self-checking bench for the dual address command router
`timescale 1ns/10ps
module dacr_router_tb
  import dacr_pkg::*;
;
  typedef struct packed {logic [4:0] sw; logic [4:0] a; logic t; logic lis; logic tlk; logic eos;} dacr_row_s;
  logic clk = 1'b0;
  logic rst_n, adv, atalk, unad, lv, lrdy, tv, trdy, rxv, txv, txrdy, err, eos, lled, tled;
  logic [4:0] sw, ad;
  logic [7:0] txd;
  dacr_byte_s ld, td;
  dacr_ser_s rx_s;
  logic [7:0] txq[$];
  int n_errors = 0;
  int checks_done = 0;

  always #50 clk = ~clk;
  // Serial transmit bytes collected mid-cycle, clear of the launching edge
  always @(negedge clk) if (txv === 1'b1) txq.push_back(txd);

  dacr_router dacr_router_inst (.CLK_I(clk), .RESETN_I(rst_n), .SW_ADDR_I(sw), .ADDR_VALID_I(adv),
    .ADDR_I(ad), .ADDR_TALK_I(atalk), .UNADDR_I(unad), .LDATA_VALID_I(lv), .LDATA_I(ld),
    .LDATA_READY_O(lrdy), .TDATA_VALID_O(tv), .TDATA_O(td), .TDATA_READY_I(trdy),
    .SER_RX_VALID_I(rxv), .SER_RX_I(rx_s), .SER_TX_VALID_O(txv), .SER_TX_DATA_O(txd),
    .SER_TX_READY_I(txrdy), .SER_ERR_O(err), .EOS_ENABLE_O(eos), .LISTEN_LED_O(lled),
    .TALK_LED_O(tled));
  dacr_bus_ctl dacr_bus_ctl_inst (.clk_i(clk), .ldata_ready_i(lrdy), .tdata_valid_i(tv),
    .tdata_i(td), .addr_valid_o(adv), .addr_o(ad), .addr_talk_o(atalk), .unaddr_o(unad),
    .ldata_valid_o(lv), .ldata_o(ld), .tdata_ready_o(trdy));

  // ----------------------------------------------------------------------
  // Compare, drive and closing tasks
  // ----------------------------------------------------------------------
  task automatic chk_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic chk_byte(input dacr_byte_s got, input dacr_byte_s exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: byte %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd_chk(input logic [7:0] d, input logic l);
    dacr_byte_s b;
    dacr_bus_ctl_inst.rd(b);
    chk_byte(b, '{d, l});
  endtask
  // Status: two count digits, CR, LF with end; counts kept below ten here
  task automatic stat_chk(input logic [7:0] c);
    rd_chk(8'h30, 1'b0);
    rd_chk(8'h30 + c, 1'b0);
    rd_chk(8'h0D, 1'b0);
    rd_chk(8'h0A, 1'b1);
  endtask
  task automatic rx(input logic [7:0] d, input logic e);
    @(posedge clk) #1;
    rxv = 1'b1;
    rx_s = '{d, e};
    @(posedge clk) #1;
    rxv = 1'b0;
    rx_s = ~rx_s;
  endtask
  // Decode takes about line length plus three cycles; forty covers a full line
  task automatic settle();
    repeat (40) @(posedge clk);
    #1;
  endtask
  task automatic final_report();
    n_errors += dacr_bus_ctl_inst.n_stall;
    $display("comparisons %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    dacr_row_s rows [9];
    string s;
    rows = '{'{5'h05, 5'h05, 1'b0, 1'b1, 1'b0, 1'b0}, '{5'h05, 5'h06, 1'b1, 1'b0, 1'b1, 1'b1},
      '{5'h05, 5'h1E, 1'b0, 1'b0, 1'b0, 1'b0}, '{5'h1E, 5'h1E, 1'b0, 1'b1, 1'b0, 1'b0},
      '{5'h1E, 5'h00, 1'b0, 1'b1, 1'b0, 1'b0}, '{5'h1E, 5'h1E, 1'b1, 1'b0, 1'b1, 1'b0},
      '{5'h1E, 5'h00, 1'b1, 1'b0, 1'b1, 1'b1}, '{5'h1E, 5'h05, 1'b0, 1'b0, 1'b0, 1'b0},
      '{5'h1E, 5'h0A, 1'b1, 1'b0, 1'b0, 1'b0}};
    s = "\r\n\377A";
    rst_n = 1'b0;
    sw = 5'h1E;
    rxv = 1'b0;
    rx_s = '0;
    txrdy = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    rst_n = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    foreach (rows[i]) begin
      sw = rows[i].sw;
      dacr_bus_ctl_inst.unaddr();
      dacr_bus_ctl_inst.addr(rows[i].a, rows[i].t);
      chk_bit(lled, rows[i].lis);
      chk_bit(tled, rows[i].tlk);
      chk_bit(eos, rows[i].eos);
    end
    $display("addressing test done");
    rx(8'hA5, 1'b1);
    chk_bit(err, 1'b1);
    dacr_bus_ctl_inst.addr(5'h1E, 1'b0);
    dacr_bus_ctl_inst.wr("STAT\r");
    settle();
    chk_bit(err, 1'b0);
    chk_bit(txq.size() == 0, 1'b1);
    dacr_bus_ctl_inst.addr(5'h1E, 1'b1);
    stat_chk(8'h01);
    rd_chk(8'h0D, 1'b0);
    rd_chk(8'h0A, 1'b1);
    dacr_bus_ctl_inst.unaddr();
    dacr_bus_ctl_inst.wr("st\r");
    settle();
    dacr_bus_ctl_inst.addr(5'h1E, 1'b1);
    rd_chk(8'h0D, 1'b0);
    rd_chk(8'h0A, 1'b1);
    $display("status test done");
    dacr_bus_ctl_inst.addr(5'h1E, 1'b0);
    dacr_bus_ctl_inst.wr("sPi 1,0\nst\r\n");
    settle();
    rx(8'h3C, 1'b1);
    chk_bit(err, 1'b0);
    dacr_bus_ctl_inst.addr(5'h1E, 1'b1);
    stat_chk(8'h01);
    dacr_bus_ctl_inst.wr("spi  0,1\r");
    settle();
    rx(8'h7E, 1'b1);
    chk_bit(err, 1'b1);
    $display("command test done");
    dacr_bus_ctl_inst.addr(5'h00, 1'b1);
    rd_chk(8'hA5, 1'b0);
    rd_chk(8'h3C, 1'b0);
    rd_chk(8'h7E, 1'b0);
    fork
      rd_chk(8'h11, 1'b0);
      begin
        repeat (5) @(posedge clk);
        #1;
        chk_bit(tv, 1'b0);
        rx(8'h11, 1'b0);
      end
    join
    dacr_bus_ctl_inst.unaddr();
    dacr_bus_ctl_inst.addr(5'h00, 1'b0);
    txrdy = 1'b0;
    fork
      dacr_bus_ctl_inst.wr(s);
      begin
        repeat (5) @(posedge clk);
        #1;
        chk_bit(txq.size() == 0, 1'b1);
        txrdy = 1'b1;
      end
    join
    repeat (3) @(posedge clk);
    #1;
    chk_bit(txq.size() == 4, 1'b1);
    foreach (txq[i]) chk_byte('{txq[i], 1'b0}, '{s[i], 1'b0});
    $display("serial test done");
    rst_n = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    rst_n = 1'b1;
    chk_bit(lled, 1'b0);
    chk_bit(tled, 1'b0);
    chk_bit(err, 1'b0);
    $display("reset test done");
    final_report();
  end

  // Whole run is a few hundred cycles; cut off at 20000 cycles, well beyond that
  initial begin
    #(20000 * 100);
    n_errors++;
    final_report();
  end
endmodule // dacr_router_tb
